/* File: design/status_reply_regs.svh */
// register offsets, field positions and link constants of the status
// query responder; definitions only, included by bare name
`ifndef STATUS_REPLY_REGS_SVH
`define STATUS_REPLY_REGS_SVH

// command code of the status query, little-endian on the link
`define STATUS_CMD_CODE 32'h73746567
// query is four bytes, reply is 54 bytes
`define QUERY_LAST_IDX 2'h3
`define REPLY_LAST_IDX 6'h35
// bytes of live fields; the rest of the reply is sent as zero
`define PAYLOAD_LEN 6'h2B
`define PAYLOAD_BITS 344
`define REPLY_BYTES 7'h36
// bit offsets of reply bytes inside the packed payload
`define PAY_MOTION_LSB 32
`define PAY_MVCMD_LSB 40
`define PAY_WIND_LSB 64
`define PAY_WIND_B_LSB 68
`define PAY_FLAGS_LSB 312

// apb register byte offsets
`define OFF_CTRL 12'h000
`define OFF_IRQ_STATUS 12'h004
`define OFF_IRQ_MASK 12'h008
`define OFF_STATUS 12'h00C
`define OFF_REPLY_COUNT 12'h010

// reset values
`define CTRL_RESET 32'h0000_0001
`define IRQ_MASK_RESET 4'h0

// control register bits
`define CTRL_ENABLE_BIT 0

// sticky event bits, low three match the reply flag word
`define EV_UNKNOWN_CMD 0
`define EV_CHECKSUM_BAD 1
`define EV_VALUE_FIXED 2
`define EV_REPLY_SENT 3
`define EV_WIDTH 4
`define CTRL_ERR_WIDTH 3

// motion-state byte bits
`define MOT_ACTIVE_BIT 0
`define MOT_TARGET_BIT 1
`define MOT_BACKLASH_BIT 2
// move-command byte bits
`define MV_ERROR_BIT 6
`define MV_RUNNING_BIT 7

`endif

/* File: design/status_reply_pkg.sv */
// types shared by the status query responder and its serializer
// assumes the offsets and bit positions of status_reply_regs.svh
package status_reply_pkg;

	typedef logic [7:0] byte_t;

	// current or last move command, low six bits of the byte
	typedef enum logic [5:0] {
		mv_unknown = 6'h00,
		mv_absolute = 6'h01,
		mv_relative = 6'h02,
		mv_left = 6'h03,
		mv_right = 6'h04,
		mv_stop = 6'h05,
		mv_home = 6'h06,
		mv_loft = 6'h07,
		mv_soft_stop = 6'h08
	} move_cmd_t;

	typedef enum logic [7:0] {
		pwr_unknown = 8'h00,
		pwr_off = 8'h01,
		pwr_nominal = 8'h03,
		pwr_reduced = 8'h04,
		pwr_maximum = 8'h05
	} pwr_state_t;

	typedef enum logic [7:0] {
		enc_absent = 8'h00,
		enc_unknown = 8'h01,
		enc_malfunction = 8'h02,
		enc_reversed = 8'h03,
		enc_ok = 8'h04
	} enc_state_t;

	// one winding; B is shifted into the high nibble
	typedef enum logic [3:0] {
		wind_absent = 4'h0,
		wind_unknown = 4'h1,
		wind_shorted = 4'h2,
		wind_ok = 4'h3
	} wind_state_t;

	typedef enum {ser_idle, ser_send} ser_state_t;

endpackage

/* File: design/reply_serializer.sv */
// byte serializer of the 54-byte status reply
// assumes a payload that stays stable while busy is high
`timescale 1ns/100ps
`include "status_reply_regs.svh"

module reply_serializer (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// request from the interpreter
	input wire logic start,
	input wire logic [`PAYLOAD_BITS-1:0] payload,
	output logic busy,
	output logic done,
	// byte stream toward the host
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data
);

	status_reply_pkg::ser_state_t state_q;
	logic [5:0] idx_q;
	logic [7:0] tx_data_q;
	logic done_q;

	// bytes past the live fields go out as zero
	function automatic status_reply_pkg::byte_t pick(
			input logic [`PAYLOAD_BITS-1:0] p, input logic [5:0] i);
		status_reply_pkg::byte_t b;
		b = 8'h00;
		if (i < `PAYLOAD_LEN) begin
			b = p[{i, 3'h0} +: 8];
		end
		return b;
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= status_reply_pkg::ser_idle;
			idx_q <= 6'h00;
			tx_data_q <= 8'h00;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				status_reply_pkg::ser_idle: begin
					if (start) begin
						state_q <= status_reply_pkg::ser_send;
						idx_q <= 6'h00;
						tx_data_q <= pick(payload, 6'h00);
					end
				end
				status_reply_pkg::ser_send: begin
					if (tx_ready) begin
						if (idx_q == `REPLY_LAST_IDX) begin
							state_q <= status_reply_pkg::ser_idle;
							done_q <= 1'b1;
						end else begin
							idx_q <= idx_q + 6'h01;
							tx_data_q <= pick(payload, idx_q + 6'h01);
						end
					end
				end
				default: begin
					state_q <= status_reply_pkg::ser_idle;
				end
			endcase
		end
	end

	assign busy = (state_q == status_reply_pkg::ser_send);
	assign tx_valid = busy;
	assign tx_data = tx_data_q;
	assign done = done_q;

	a_tx_hold_stall: assert property (@(posedge pclk)
		disable iff (!presetn)
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte changed while stalled");

endmodule

/* File: design/motion_status_query_reply.sv */
// status query responder: takes 4-byte queries, answers with 54 bytes
// assumes status inputs from the motion core are synchronous to pclk
//
// Operation
// - host sends 4-byte status code; device answers 54 bytes echoing it
// - motion-state bit 0x1 set while the motor is being driven
// - bit 0x2 on target speed reached; bit 0x4 during backlash motion
// - low six bits of move-command byte name the current or last move
// - move-command bit 0x40 marks a move that ended in error
// - move-command bit 0x80 high while a move command runs
// - winding power state reported as one of five stepper codes
// - encoder state reported as one of five codes
// - low nibble of winding byte gives winding A state
// - high nibble of winding byte gives winding B state
// - signed whole, microstep and 64-bit encoder positions reported
// - signed whole speed and signed fractional speed reported
// - currents, voltages and temperature reported as signed 16-bit
// - flag word low six bits are controller errors; 0x1 unknown command (only the low three bits are driven here)
// - flag 0x2 set when a command's checksum does not match
// - flag 0x4 set when command values were corrected into range
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "status_reply_regs.svh"

module motion_status_query_reply (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// query byte stream from the host
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_data,
	// reply byte stream to the host
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	// error events from the command front end
	input wire logic checksum_mismatch_flag,
	input wire logic value_corrected_flag,
	// motion state
	input wire logic motion_active_flag,
	input wire logic target_speed_flag,
	input wire logic backlash_comp_flag,
	input wire status_reply_pkg::move_cmd_t move_command_id_field,
	input wire logic move_finished_with_error_bit,
	input wire logic move_command_running_bit,
	input wire status_reply_pkg::pwr_state_t winding_power_state,
	input wire status_reply_pkg::enc_state_t encoder_state,
	input wire status_reply_pkg::wind_state_t winding_a_state,
	input wire status_reply_pkg::wind_state_t winding_b_state,
	// positions and speed
	input wire logic signed [31:0] whole_position,
	input wire logic signed [15:0] microstep_position,
	input wire logic signed [63:0] encoder_position,
	input wire logic signed [31:0] whole_speed,
	input wire logic signed [15:0] fractional_speed,
	// electrical measurements
	input wire logic signed [15:0] engine_current,
	input wire logic signed [15:0] supply_voltage,
	input wire logic signed [15:0] usb_current,
	input wire logic signed [15:0] usb_voltage,
	input wire logic signed [15:0] temperature_reading,
	// interrupt
	output logic irq
);

	logic [31:0] ctrl_q;
	logic [`EV_WIDTH-1:0] irq_status_q;
	logic [`EV_WIDTH-1:0] irq_mask_q;
	logic [15:0] reply_count_q;
	logic [31:0] prdata_q;
	logic [31:0] query_q;
	logic [1:0] rx_cnt_q;
	logic start_q;
	logic [`PAYLOAD_BITS-1:0] snap_q;
	logic ser_busy;
	logic ser_done;
	logic rx_take;
	logic last_byte;
	logic [31:0] query_word;
	logic query_match;
	logic query_unknown;
	logic apb_setup;
	logic apb_write;
	logic addr_ok;
	logic [`EV_WIDTH-1:0] ev_set;
	logic [`EV_WIDTH-1:0] ev_clr;

	// reply fields in listed order; concatenation puts the low byte last
	function automatic logic [`PAYLOAD_BITS-1:0] pack_reply(
			input logic [`CTRL_ERR_WIDTH-1:0] errs);
		logic [7:0] motion;
		logic [7:0] mvcmd;
		logic [7:0] wind;
		logic [31:0] flags;
		motion = 8'h00;
		motion[`MOT_ACTIVE_BIT] = motion_active_flag;
		motion[`MOT_TARGET_BIT] = target_speed_flag;
		motion[`MOT_BACKLASH_BIT] = backlash_comp_flag;
		mvcmd = {2'h0, move_command_id_field};
		mvcmd[`MV_ERROR_BIT] = move_finished_with_error_bit;
		mvcmd[`MV_RUNNING_BIT] = move_command_running_bit;
		wind = {winding_b_state, winding_a_state};
		flags = 32'h0000_0000;
		flags[`CTRL_ERR_WIDTH-1:0] = errs;
		pack_reply = {flags, temperature_reading, usb_voltage,
			usb_current, supply_voltage, engine_current,
			fractional_speed, whole_speed,
			encoder_position, microstep_position, whole_position,
			wind, encoder_state, winding_power_state,
			mvcmd, motion, `STATUS_CMD_CODE};
	endfunction

	function automatic logic known_offset(input logic [11:0] a);
		known_offset = (a == `OFF_CTRL) || (a == `OFF_IRQ_STATUS) ||
			(a == `OFF_IRQ_MASK) || (a == `OFF_STATUS) ||
			(a == `OFF_REPLY_COUNT);
	endfunction

	// query side: one byte a cycle, low byte first
	// a stall while replying keeps queries from overlapping replies
	assign rx_ready = ctrl_q[`CTRL_ENABLE_BIT] && !ser_busy && !start_q;
	assign rx_take = rx_valid && rx_ready;
	assign last_byte = rx_take && (rx_cnt_q == `QUERY_LAST_IDX);
	assign query_word = {rx_data, query_q[31:8]};
	assign query_match = last_byte && (query_word == `STATUS_CMD_CODE);
	assign query_unknown = last_byte && (query_word != `STATUS_CMD_CODE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			query_q <= 32'h0000_0000;
			rx_cnt_q <= 2'h0;
		end else if (rx_take) begin
			query_q <= query_word;
			rx_cnt_q <= rx_cnt_q + 2'h1;
		end
	end

	// snapshot freezes every field at once so the reply is coherent
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q <= 1'b0;
			snap_q <= '0;
		end else begin
			start_q <= query_match;
			if (query_match) begin
				snap_q <= pack_reply(irq_status_q[`CTRL_ERR_WIDTH-1:0]);
			end
		end
	end

	reply_serializer u_ser (
		.pclk(pclk),
		.presetn(presetn),
		.start(start_q),
		.payload(snap_q),
		.busy(ser_busy),
		.done(ser_done),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.tx_data(tx_data)
	);

	// apb: zero wait states, read data latched in the setup cycle
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite;
	assign addr_ok = known_offset(paddr);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (apb_setup && !pwrite) begin
			case (paddr)
				`OFF_CTRL: begin
					prdata_q <= ctrl_q;
				end
				`OFF_IRQ_STATUS: begin
					prdata_q <= {28'h0, irq_status_q};
				end
				`OFF_IRQ_MASK: begin
					prdata_q <= {28'h0, irq_mask_q};
				end
				`OFF_STATUS: begin
					prdata_q <= {29'h0, rx_cnt_q, ser_busy};
				end
				`OFF_REPLY_COUNT: begin
					prdata_q <= {16'h0, reply_count_q};
				end
				default: begin
					prdata_q <= 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CTRL_RESET;
		end else if (apb_write && paddr == `OFF_CTRL) begin
			ctrl_q <= {31'h0, pwdata[`CTRL_ENABLE_BIT]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= `IRQ_MASK_RESET;
		end else if (apb_write && paddr == `OFF_IRQ_MASK) begin
			irq_mask_q <= pwdata[`EV_WIDTH-1:0];
		end
	end

	// sticky events; a set in the clearing cycle wins
	always_comb begin
		ev_set = '0;
		ev_set[`EV_UNKNOWN_CMD] = query_unknown;
		ev_set[`EV_CHECKSUM_BAD] = checksum_mismatch_flag;
		ev_set[`EV_VALUE_FIXED] = value_corrected_flag;
		ev_set[`EV_REPLY_SENT] = ser_done;
		ev_clr = '0;
		if (apb_write && paddr == `OFF_IRQ_STATUS) begin
			ev_clr = pwdata[`EV_WIDTH-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= (irq_status_q & ~ev_clr) | ev_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reply_count_q <= 16'h0000;
		end else if (ser_done) begin
			reply_count_q <= reply_count_q + 16'h0001;
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

	// checking helpers: bytes handed over in the current reply
	logic [6:0] sent_cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sent_cnt_q <= 7'h00;
		end else if (start_q) begin
			sent_cnt_q <= 7'h00;
		end else if (tx_valid && tx_ready) begin
			sent_cnt_q <= sent_cnt_q + 7'h01;
		end
	end

	sequence s_query_taken;
		query_match;
	endsequence

	sequence s_reply_opens;
		##1 start_q ##1 tx_valid && tx_data == 8'(`STATUS_CMD_CODE);
	endsequence

	a_query_reply_start: assert property (@(posedge pclk)
		disable iff (!presetn) s_query_taken |-> s_reply_opens)
		else $error("status query did not open a reply with its code");

	a_reply_byte_count: assert property (@(posedge pclk)
		disable iff (!presetn)
		$rose(ser_done) |-> sent_cnt_q == `REPLY_BYTES)
		else $error("reply length is not 54 bytes");

	a_motion_active_bit: assert property (@(posedge pclk)
		disable iff (!presetn) start_q |->
		snap_q[`PAY_MOTION_LSB + `MOT_ACTIVE_BIT] ==
		$past(motion_active_flag))
		else $error("motion-active bit not captured");

	a_target_bit: assert property (@(posedge pclk)
		disable iff (!presetn) start_q |->
		snap_q[`PAY_MOTION_LSB + `MOT_TARGET_BIT] ==
		$past(target_speed_flag))
		else $error("target-speed bit not captured");

	a_backlash_bit: assert property (@(posedge pclk)
		disable iff (!presetn) start_q |->
		snap_q[`PAY_MOTION_LSB + `MOT_BACKLASH_BIT] ==
		$past(backlash_comp_flag))
		else $error("backlash bit not captured");

	a_move_id_field: assert property (@(posedge pclk)
		disable iff (!presetn) start_q |->
		snap_q[`PAY_MVCMD_LSB +: 6] == $past(move_command_id_field))
		else $error("move command id not captured");

	a_move_error_bit: assert property (@(posedge pclk)
		disable iff (!presetn) start_q |->
		snap_q[`PAY_MVCMD_LSB + `MV_ERROR_BIT] ==
		$past(move_finished_with_error_bit))
		else $error("move error bit not captured");

	a_running_bit: assert property (@(posedge pclk)
		disable iff (!presetn) start_q |->
		snap_q[`PAY_MVCMD_LSB + `MV_RUNNING_BIT] ==
		$past(move_command_running_bit))
		else $error("running bit not captured");

	a_winding_a_nibble: assert property (@(posedge pclk)
		disable iff (!presetn) start_q |->
		snap_q[`PAY_WIND_LSB +: 4] == $past(winding_a_state))
		else $error("winding A not in low nibble");

	a_winding_b_nibble: assert property (@(posedge pclk)
		disable iff (!presetn) start_q |->
		snap_q[`PAY_WIND_B_LSB +: 4] == $past(winding_b_state))
		else $error("winding B not in high nibble");

	a_flag_word_echo: assert property (@(posedge pclk)
		disable iff (!presetn) start_q |->
		snap_q[`PAY_FLAGS_LSB +: `CTRL_ERR_WIDTH] ==
		$past(irq_status_q[`CTRL_ERR_WIDTH-1:0]))
		else $error("controller error flags not echoed");

	a_unknown_cmd_flag: assert property (@(posedge pclk)
		disable iff (!presetn) query_unknown |=>
		irq_status_q[`EV_UNKNOWN_CMD] && !start_q)
		else $error("unknown query not flagged");

	a_checksum_flag: assert property (@(posedge pclk)
		disable iff (!presetn) checksum_mismatch_flag |=>
		irq_status_q[`EV_CHECKSUM_BAD])
		else $error("checksum event lost");

	a_value_fixed_flag: assert property (@(posedge pclk)
		disable iff (!presetn) value_corrected_flag |=>
		irq_status_q[`EV_VALUE_FIXED])
		else $error("value correction event lost");

	a_rx_stall_busy: assert property (@(posedge pclk)
		disable iff (!presetn) ser_busy |-> !rx_ready)
		else $error("query accepted during a reply");

	a_apb_unmapped: assert property (@(posedge pclk)
		disable iff (!presetn) psel && penable && !addr_ok |->
		pslverr && pready)
		else $error("unmapped access not refused");

endmodule

/* File: verification/host_link_model.sv */
// host side of the query link: sends queries, collects reply bytes
// assumes the responder's rx/tx byte handshakes on pclk
`timescale 1ns/100ps

module host_link_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// query bytes toward the device
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	// reply bytes from the device
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data
);
	logic [7:0] got_q[$];
	integer stall_seed = 32'h3F3D;

	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end

	// random stalls so the held tx_data path is exercised
	always @(posedge pclk) begin
		if (tx_valid && tx_ready)
			got_q.push_back(tx_data);
		tx_ready <= presetn && (($random(stall_seed) & 3) != 0);
	end

	// four bytes low first, each held until taken
	task send_word(input logic [31:0] w);
		int i;
		for (i = 0; i < 4; i++) begin
			rx_valid <= 1'b1;
			rx_data <= w[i*8+:8];
			// ready judged settled, so a byte is never offered twice
			@(negedge pclk);
			while (rx_ready !== 1'b1)
				@(negedge pclk);
			@(posedge pclk);
		end
		rx_valid <= 1'b0;
		// released line shows the inverse, not a stale byte
		rx_data <= ~w[31:24];
	endtask
endmodule

/* File: verification/motion_status_query_reply_tb.sv */
// self-checking bench of the status query responder
// assumes zero-wait apb and the host model on the byte link
`timescale 1ns/100ps
`include "status_reply_regs.svh"

module motion_status_query_reply_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic rx_valid, rx_ready, tx_valid, tx_ready;
	logic [7:0] rx_data, tx_data;
	logic checksum_mismatch_flag, value_corrected_flag;
	logic motion_active_flag, target_speed_flag, backlash_comp_flag;
	logic move_finished_with_error_bit, move_command_running_bit;
	status_reply_pkg::move_cmd_t move_command_id_field;
	status_reply_pkg::pwr_state_t winding_power_state;
	status_reply_pkg::enc_state_t encoder_state;
	status_reply_pkg::wind_state_t winding_a_state, winding_b_state;
	logic signed [31:0] whole_position, whole_speed;
	logic signed [63:0] encoder_position;
	logic signed [15:0] microstep_position, fractional_speed;
	logic signed [15:0] engine_current, supply_voltage, usb_current;
	logic signed [15:0] usb_voltage, temperature_reading;
	int n_mismatch = 0;
	int num_checks = 0;
	integer seed = 32'h3F3D;
	logic [31:0] rd;
	logic err;

	motion_status_query_reply u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data),
		.checksum_mismatch_flag(checksum_mismatch_flag),
		.value_corrected_flag(value_corrected_flag),
		.motion_active_flag(motion_active_flag),
		.target_speed_flag(target_speed_flag),
		.backlash_comp_flag(backlash_comp_flag),
		.move_command_id_field(move_command_id_field),
		.move_finished_with_error_bit(move_finished_with_error_bit),
		.move_command_running_bit(move_command_running_bit),
		.winding_power_state(winding_power_state),
		.encoder_state(encoder_state),
		.winding_a_state(winding_a_state),
		.winding_b_state(winding_b_state),
		.whole_position(whole_position),
		.microstep_position(microstep_position),
		.encoder_position(encoder_position), .whole_speed(whole_speed),
		.fractional_speed(fractional_speed),
		.engine_current(engine_current), .supply_voltage(supply_voltage),
		.usb_current(usb_current), .usb_voltage(usb_voltage),
		.temperature_reading(temperature_reading), .irq(irq));

	host_link_model hl (.pclk(pclk), .presetn(presetn),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s exp %h got %h", nm, exp, got);
		end
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one transfer: setup, access held until pready
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd_chk(input string nm, input logic [11:0] a, input logic [32:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, {31'h0, exp}, {31'h0, err, rd});
	endtask

	function automatic logic [431:0] exp_reply(input logic [31:0] fl);
		return {88'h0, fl, temperature_reading, usb_voltage, usb_current,
			supply_voltage, engine_current, fractional_speed, whole_speed,
			encoder_position, microstep_position, whole_position,
			winding_b_state, winding_a_state, encoder_state,
			winding_power_state, move_command_running_bit,
			move_finished_with_error_bit, move_command_id_field, 5'h00,
			backlash_comp_flag, target_speed_flag, motion_active_flag,
			`STATUS_CMD_CODE};
	endfunction

	task rand_inputs(input int k);
		logic [31:0] r0, r1, r2, r3;
		status_reply_pkg::pwr_state_t pwr_tab[5];
		pwr_tab = '{status_reply_pkg::pwr_unknown, status_reply_pkg::pwr_off,
			status_reply_pkg::pwr_nominal, status_reply_pkg::pwr_reduced,
			status_reply_pkg::pwr_maximum};
		r0 = $random(seed);
		r1 = (k == 0) ? 32'h8000_0000 : $random(seed);
		r2 = $random(seed);
		r3 = $random(seed);
		{motion_active_flag, target_speed_flag, backlash_comp_flag,
			move_finished_with_error_bit, move_command_running_bit} <= r0[4:0];
		move_command_id_field <= status_reply_pkg::move_cmd_t'(6'(k));
		winding_power_state <= pwr_tab[k % 5];
		encoder_state <= status_reply_pkg::enc_state_t'(8'(k % 5));
		winding_a_state <= status_reply_pkg::wind_state_t'(4'(k % 4));
		winding_b_state <= status_reply_pkg::wind_state_t'(4'((k + 1) % 4));
		whole_position <= r1;
		encoder_position <= {r1, r3};
		microstep_position <= r2[15:0];
		fractional_speed <= r2[31:16];
		whole_speed <= r3;
		engine_current <= r0[31:16];
		supply_voltage <= r1[15:0];
		usb_current <= r3[31:16];
		usb_voltage <= r3[15:0];
		temperature_reading <= r1[31:16];
	endtask

	// reply end judged by the byte stream, not motion flag
	task run_query(input logic [31:0] fl);
		logic [431:0] ex;
		int n;
		@(posedge pclk);
		ex = exp_reply(fl);
		hl.got_q.delete();
		hl.send_word(`STATUS_CMD_CODE);
		for (n = 0; n < 3000 && (hl.got_q.size() < 54 || tx_valid); n++)
			@(posedge pclk);
		chk("reply length", 64'h36, 64'(hl.got_q.size()));
		for (n = 0; n < 54; n++)
			chk("reply byte", 64'(ex[n*8+:8]), 64'(hl.got_q[n]));
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{checksum_mismatch_flag, value_corrected_flag} = 2'b00;
		rand_inputs(0);
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("ctrl", `OFF_CTRL, {1'b0, `CTRL_RESET});
		rd_chk("irq mask", `OFF_IRQ_MASK, 33'h0);
		rd_chk("irq status", `OFF_IRQ_STATUS, 33'h0);
		rd_chk("reply count", `OFF_REPLY_COUNT, 33'h0);
		rd_chk("status", `OFF_STATUS, 33'h0);
		rd_chk("unmapped", 12'h014, 33'h1_0000_0000);
		$display("register reset test done");
		for (int k = 0; k < 9; k++) begin
			rand_inputs(k);
			run_query(32'h0);
		end
		rd_chk("reply count", `OFF_REPLY_COUNT, 33'h9);
		rd_chk("irq status", `OFF_IRQ_STATUS, 33'h8);
		$display("status reply test done");
		hl.send_word(32'h1122_3344);
		checksum_mismatch_flag <= 1'b1;
		value_corrected_flag <= 1'b1;
		@(posedge pclk);
		{checksum_mismatch_flag, value_corrected_flag} <= 2'b00;
		rd_chk("irq status", `OFF_IRQ_STATUS, 33'hF);
		apb(1'b1, `OFF_IRQ_MASK, 32'h1);
		@(posedge pclk);
		chk("irq", 64'h1, 64'(irq));
		run_query(32'h7);
		apb(1'b1, `OFF_IRQ_STATUS, 32'hF);
		rd_chk("irq status", `OFF_IRQ_STATUS, 33'h0);
		chk("irq", 64'h0, 64'(irq));
		$display("error flag test done");
		apb(1'b1, `OFF_CTRL, 32'h0);
		@(posedge pclk);
		chk("rx ready off", 64'h0, 64'(rx_ready));
		apb(1'b1, `OFF_CTRL, 32'h1);
		@(posedge pclk);
		chk("rx ready on", 64'h1, 64'(rx_ready));
		run_query(32'h0);
		$display("enable test done");
		summarize;
	end

	initial begin
		repeat (50000) @(posedge pclk);
		n_mismatch++;
		summarize;
	end
endmodule
